/* File: common/spism_pkg.sv */
// Constants shared by the slave-mode serial engine
`default_nettype none
package spism_pkg;

  // Data path
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BIT_CNT_W  = 4;
  localparam int unsigned XFER_CNT_W = 16;

  // Bits per byte; a byte completes on the sample taken at bit count BIT_CNT_FULL - 1
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;

  // Status flag positions in flag_status / flag_clear
  localparam int unsigned FLAG_COUNT     = 6;
  localparam int unsigned FLAG_TX_UNDER  = 0;
  localparam int unsigned FLAG_RX_OVER   = 1;
  localparam int unsigned FLAG_SEL_FAULT = 2;
  localparam int unsigned FLAG_SEL_START = 3;
  localparam int unsigned FLAG_SEL_END   = 4;
  localparam int unsigned FLAG_CNT_ZERO  = 5;

  // Values after reset, and the transfer counter step
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] XFER_CNT_RST = 16'h0000;
  localparam logic [15:0] XFER_CNT_ONE = 16'h0001;
  localparam logic [5:0]  FLAGS_RESET  = 6'h00;
  localparam logic [2:0]  SYNC_RESET   = 3'h0;

  // Select tracking
  typedef enum logic [0:0] {
    SPISM_SEL_IDLE,
    SPISM_SEL_ACTIVE
  } spism_sel_e;

endpackage : spism_pkg
`default_nettype wire

/* File: rtl/spism_engine.sv */
// Slave-mode serial engine with transmit and receive queues
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Queue of WIDTH-bit words, DEPTH entries, valid/ready on both sides
module spism_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // Storage
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (do_wr && !do_rd) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end
endmodule : spism_fifo

////////////////////////////////////////////////////////////////////////////////
module spism_engine (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        sck_in,
  input  wire logic        ss_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe,
  output logic             sck_out,
  output logic             sck_out_oe,
  input  wire logic        sck_split,
  input  wire logic        pin_direction_bit,
  input  wire logic        pin_latch_bit,
  input  wire logic        tx_data_required,
  input  wire logic        rx_data_required,
  input  wire logic        select_polarity,
  input  wire logic        select_force,
  input  wire logic        clock_polarity_sel,
  input  wire logic        clock_edge_sel,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [7:0]  rx_data,
  input  wire logic        count_load,
  input  wire logic [7:0]  transfer_count_low,
  output logic      [15:0] transfer_count,
  output logic             tx_fifo_empty_flag,
  output logic      [5:0]  flag_status,
  input  wire logic [5:0]  flag_clear
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]              sck_sync_q;
  logic [1:0]              ss_sync_q;
  logic [1:0]              sdi_sync_q;
  spism_pkg::spism_sel_e   sel_q;
  logic                    sel_act;
  logic                    sel_rise;
  logic                    sel_fall;
  logic                    sck_lead;
  logic                    sck_trail;
  logic                    sample_ev;
  logic                    shift_ev;
  logic [3:0]              bit_cnt_q;
  logic                    loaded_q;
  logic                    load_now;
  logic                    byte_done;
  logic [7:0]              tx_sh_q;
  logic [7:0]              rx_sh_q;
  logic [7:0]              rx_byte;
  logic [7:0]              last_rx_q;
  logic [15:0]             xfer_cnt_q;
  logic [5:0]              flags_q;
  logic [5:0]              flag_set;
  logic                    txq_valid;
  logic [7:0]              txq_data;
  logic                    txq_pop;
  logic                    src_q;
  logic                    src_fifo;
  logic                    first_sample;
  logic                    rxq_ready;
  logic                    rxq_push;
  logic                    sdo_out_q;
  logic                    sdo_oe_q;
  logic                    sck_out_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (reset) begin
      sck_sync_q <= spism_pkg::SYNC_RESET;
      ss_sync_q  <= spism_pkg::SYNC_RESET[1:0];
      sdi_sync_q <= spism_pkg::SYNC_RESET[1:0];
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], sck_in ^ clock_polarity_sel};
      ss_sync_q  <= {ss_sync_q[0], ss_in};
      sdi_sync_q <= {sdi_sync_q[0], sdi_in};
    end
  end

  // Effective select
  assign sel_act = select_force | (select_polarity ? ~ss_sync_q[1] : ss_sync_q[1]);

  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_q <= spism_pkg::SPISM_SEL_IDLE;
    end else begin
      sel_q <= sel_act ? spism_pkg::SPISM_SEL_ACTIVE : spism_pkg::SPISM_SEL_IDLE;
    end
  end

  assign sel_rise = sel_act & (sel_q == spism_pkg::SPISM_SEL_IDLE);
  assign sel_fall = ~sel_act & (sel_q == spism_pkg::SPISM_SEL_ACTIVE);

  // Clock edges, qualified by select
  assign sck_lead  = sel_act & sck_sync_q[1] & ~sck_sync_q[2];
  assign sck_trail = sel_act & ~sck_sync_q[1] & sck_sync_q[2];
  assign sample_ev = clock_edge_sel ? sck_lead : sck_trail;
  assign shift_ev  = clock_edge_sel ? sck_trail : sck_lead;

  //////////////////////////////////////////////////////////////////////////////
  // Bit sequencing
  assign load_now  = sel_act & ~loaded_q & (bit_cnt_q == '0);
  assign byte_done = sample_ev & (bit_cnt_q == spism_pkg::BIT_CNT_FULL - 4'h1);
  assign rx_byte   = {rx_sh_q[6:0], sdi_sync_q[1]};

  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_cnt_q <= '0;
      loaded_q  <= 1'b0;
    end else if (!sel_act) begin
      bit_cnt_q <= '0;
      loaded_q  <= 1'b0;
    end else if (byte_done) begin
      bit_cnt_q <= '0;
      loaded_q  <= 1'b0;
    end else begin
      if (sample_ev) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (load_now) begin
        loaded_q <= 1'b1;
      end
    end
  end

  // Transmit shifter; pop and underflow commit at the first sample of a byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      src_q <= 1'b0;
    end else if (load_now) begin
      src_q <= txq_valid;
    end
  end

  assign src_fifo     = load_now ? txq_valid : src_q;
  assign first_sample = sample_ev & (bit_cnt_q == '0);
  assign txq_pop      = first_sample & tx_data_required & src_fifo;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_sh_q <= spism_pkg::BYTE_RESET;
    end else if (load_now) begin
      tx_sh_q <= txq_valid ? txq_data : last_rx_q;
    end else if (shift_ev && bit_cnt_q != '0) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // Receive shifter and last byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_sh_q   <= spism_pkg::BYTE_RESET;
      last_rx_q <= spism_pkg::BYTE_RESET;
    end else begin
      if (sample_ev) begin
        rx_sh_q <= rx_byte;
      end
      if (byte_done) begin
        last_rx_q <= rx_byte;
      end
    end
  end

  assign rxq_push = byte_done & rx_data_required;

  //////////////////////////////////////////////////////////////////////////////
  // Transfer counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      xfer_cnt_q <= spism_pkg::XFER_CNT_RST;
    end else if (count_load) begin
      xfer_cnt_q <= {8'h00, transfer_count_low};
    end else if (byte_done) begin
      xfer_cnt_q <= xfer_cnt_q - spism_pkg::XFER_CNT_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over clear
  always_comb begin
    flag_set = '0;
    flag_set[spism_pkg::FLAG_TX_UNDER]  = first_sample & tx_data_required & ~src_fifo;
    flag_set[spism_pkg::FLAG_RX_OVER]   = rxq_push & ~rxq_ready;
    flag_set[spism_pkg::FLAG_SEL_FAULT] = sel_fall & ~select_force &
                                          ((bit_cnt_q != '0) | ~xfer_cnt_q[15] & (xfer_cnt_q != '0));
    flag_set[spism_pkg::FLAG_SEL_START] = sel_rise;
    flag_set[spism_pkg::FLAG_SEL_END]   = sel_fall;
    flag_set[spism_pkg::FLAG_CNT_ZERO]  = byte_done & ~count_load &
                                          (xfer_cnt_q == spism_pkg::XFER_CNT_ONE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q <= spism_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clear);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial data and forwarded clock pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      sdo_out_q <= 1'b0;
      sdo_oe_q  <= 1'b0;
      sck_out_q <= 1'b0;
    end else begin
      if (!pin_direction_bit) begin
        sdo_oe_q  <= 1'b1;
        sdo_out_q <= sel_act ? tx_sh_q[7] : pin_latch_bit;
      end else begin
        sdo_oe_q  <= tx_data_required & sel_act;
        sdo_out_q <= tx_sh_q[7];
      end
      sck_out_q <= sck_sync_q[1] ^ clock_polarity_sel;
    end
  end

  assign sdo_out    = sdo_out_q;
  assign sdo_oe     = sdo_oe_q;
  assign sck_out    = sck_out_q;
  assign sck_out_oe = sck_split;

  //////////////////////////////////////////////////////////////////////////////
  // Queues
  spism_fifo #(
    .WIDTH (spism_pkg::BYTE_BITS),
    .DEPTH (spism_pkg::FIFO_DEPTH)
  ) u_txq (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (txq_valid),
    .out_ready (txq_pop),
    .out_data  (txq_data)
  );

  spism_fifo #(
    .WIDTH (spism_pkg::BYTE_BITS),
    .DEPTH (spism_pkg::FIFO_DEPTH)
  ) u_rxq (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (rxq_push),
    .in_ready  (rxq_ready),
    .in_data   (rx_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign transfer_count     = xfer_cnt_q;
  assign tx_fifo_empty_flag = ~txq_valid;
  assign flag_status        = flags_q;

endmodule : spism_engine
`default_nettype wire

/* File: tb/spism_engine_asserts.sv */
// Checker for the slave-mode serial engine ports
`timescale 1ns/10ps
`default_nettype none
module spism_engine_asserts (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ss_in,
  input wire logic        sdo_out,
  input wire logic        sdo_oe,
  input wire logic        sck_out_oe,
  input wire logic        sck_split,
  input wire logic        pin_direction_bit,
  input wire logic        pin_latch_bit,
  input wire logic        tx_data_required,
  input wire logic        select_polarity,
  input wire logic        select_force,
  input wire logic        count_load,
  input wire logic [7:0]  transfer_count_low,
  input wire logic [15:0] transfer_count,
  input wire logic [5:0]  flag_status,
  input wire logic [5:0]  flag_clear
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic idle;
  assign idle = !select_force && ss_in == select_polarity;
  a_drive_always: assert property (!pin_direction_bit [*3] |-> sdo_oe) else $error("sdo undriven");
  a_idle_latch: assert property ((idle && !pin_direction_bit && $stable(pin_latch_bit)) [*6]
    |-> sdo_out == pin_latch_bit) else $error("idle level wrong");
  a_tristate_off: assert property ((pin_direction_bit && (idle || !tx_data_required)) [*6]
    |-> !sdo_oe) else $error("sdo driven");
  a_split_clock: assert property (sck_out_oe == sck_split) else $error("clock enable wrong");
  a_flags_sticky: assert property (($past(flag_status) & ~$past(flag_clear) & ~flag_status) == 6'h00)
    else $error("flag lost");
  a_count_step: assert property (!$past(count_load) && transfer_count != $past(transfer_count)
    |-> transfer_count == $past(transfer_count) - 16'h0001) else $error("count jump");
  a_count_load: assert property (count_load |=> transfer_count == {8'h00, $past(transfer_count_low)})
    else $error("load wrong");
  a_zero_flag: assert property ($rose(flag_status[5]) |-> transfer_count == 16'h0000
    && ($past(transfer_count) == 16'h0001 || $past(transfer_count, 2) == 16'h0001))
    else $error("zero flag wrong");
  a_forced_nofault: assert property (select_force [*4] |-> !$rose(flag_status[2]))
    else $error("fault while forced");
  a_under_needs_tx: assert property ($rose(flag_status[0]) |-> tx_data_required)
    else $error("underflow wrong");
  c_overflow: cover property ($rose(flag_status[1]));
  c_zero: cover property ($rose(flag_status[5]));
  c_fault: cover property ($rose(flag_status[2]));
endmodule : spism_engine_asserts
bind spism_engine spism_engine_asserts u_spism_engine_asserts (.mclk, .reset, .ss_in, .sdo_out, .sdo_oe,
  .sck_out_oe, .sck_split, .pin_direction_bit, .pin_latch_bit, .tx_data_required, .select_polarity,
  .select_force, .count_load, .transfer_count_low, .transfer_count, .flag_status, .flag_clear);
`default_nettype wire

/* File: tb/spism_master_model.sv */
// Serial bus master model: clock, select and data
`timescale 1ns/10ps
`default_nettype none
module spism_master_model (
  input  wire logic select_polarity,
  input  wire logic clock_polarity_sel,
  input  wire logic sdo,
  output logic      sck,
  output logic      ss,
  output logic      sdi
);
  task automatic rest;
    ss = select_polarity;
    sck = clock_polarity_sel;
    sdi = 1'b0;
  endtask : rest
  task automatic frame(input logic [7:0] d, input int nbits, output logic [7:0] q);
    ss = !select_polarity;
    #125;
    for (int i = 0; i < nbits; i++) begin
      sdi = d[7 - i];
      #62.5 sck = !clock_polarity_sel;
      q = {q[6:0], sdo};
      #62.5 sck = clock_polarity_sel;
    end
    sdi = !sdi;
    #62.5 ss = select_polarity;
    #125;
  endtask : frame
endmodule : spism_master_model
`default_nettype wire

/* File: tb/test_spism_engine.sv */
// Self-checking bench for the slave-mode serial engine
`timescale 1ns/10ps
`default_nettype none
module test_spism_engine;
  logic        mclk, reset, sck_in, ss_in, sdi_in, sdo_out, sdo_oe, sck_out, sck_out_oe, sck_split;
  logic        pin_direction_bit, pin_latch_bit, tx_data_required, rx_data_required, select_polarity;
  logic        select_force, clock_polarity_sel, clock_edge_sel, tx_valid, tx_ready, rx_valid, rx_ready;
  logic        count_load, tx_fifo_empty_flag;
  logic [7:0]  tx_data, rx_data, transfer_count_low, q, last, prev;
  logic [15:0] transfer_count;
  logic [5:0]  flag_status, flag_clear;
  logic [7:0]  exp_q[$];
  logic [7:0]  pushed[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  spism_engine u_spism_engine (.mclk, .reset, .sck_in, .ss_in, .sdi_in, .sdo_out, .sdo_oe, .sck_out,
    .sck_out_oe, .sck_split, .pin_direction_bit, .pin_latch_bit, .tx_data_required, .rx_data_required,
    .select_polarity, .select_force, .clock_polarity_sel, .clock_edge_sel, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_ready, .rx_data, .count_load, .transfer_count_low, .transfer_count,
    .tx_fifo_empty_flag, .flag_status, .flag_clear);
  spism_master_model u_spism_master_model (.select_polarity, .clock_polarity_sel, .sdo(sdo_out),
    .sck(sck_in), .ss(ss_in), .sdi(sdi_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic fill(input int n);
    logic [7:0] d;
    tx_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      pushed.push_back(d);
      tx_data <= d;
      @(posedge mclk);
    end
    tx_valid <= 1'b0;
    @(posedge mclk);
  endtask : fill
  task automatic xfer(input int nbits, input logic store);
    logic [7:0] d;
    d = 8'($urandom);
    if (store) exp_q.push_back(d);
    u_spism_master_model.frame(d, nbits, q);
    if (nbits == 8) last = d;
    @(posedge mclk);
  endtask : xfer
  task automatic settle_clear;
    repeat (8) @(posedge mclk);
    flag_clear <= 6'h3f;
    @(posedge mclk);
    flag_clear <= 6'h00;
    @(posedge mclk);
  endtask : settle_clear
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  always @(posedge mclk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) check("rx_data", rx_data, exp_q.pop_front());
  end
  initial begin
    void'($urandom(17));
    {reset, clock_edge_sel} = 2'b11;
    {pin_direction_bit, tx_data_required, rx_data_required, select_force, tx_valid, rx_ready} = 6'h00;
    {select_polarity, clock_polarity_sel, pin_latch_bit, sck_split} = 4'($urandom);
    {count_load, tx_data, transfer_count_low, flag_clear} = 23'h00_0000;
    #1;
    u_spism_master_model.rest();
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    {tx_data_required, rx_data_required, rx_ready, count_load} <= 4'hf;
    transfer_count_low <= 8'h02;
    @(posedge mclk);
    count_load <= 1'b0;
    fill(2);
    for (int i = 0; i < 2; i++) begin
      xfer(8, 1'b1);
      check("master_rx", q, pushed.pop_front());
    end
    settle_clear();
    check("empty", tx_fifo_empty_flag, 1'b1);
    $display("test basic done");
    {tx_data_required, rx_ready} <= 2'b00;
    fill(8);
    check("tx_ready", tx_ready, 1'b0);
    for (int i = 0; i < 9; i++) begin
      xfer(8, i < 8);
      check("master_rx", q, pushed[0]);
    end
    repeat (8) @(posedge mclk);
    check("overflow", flag_status[1], 1'b1);
    rx_ready <= 1'b1;
    repeat (20) @(posedge mclk);
    check("rx_left", exp_q.size(), 16'h0000);
    $display("test overflow done");
    settle_clear();
    {tx_data_required, rx_data_required} <= 2'b10;
    for (int i = 0; i < 8; i++) begin
      xfer(8, 1'b0);
      check("master_rx", q, pushed.pop_front());
    end
    check("empty", tx_fifo_empty_flag, 1'b1);
    prev = last;
    xfer(8, 1'b0);
    check("echo", q, prev);
    repeat (8) @(posedge mclk);
    check("underflow_set", flag_status[0], 1'b1);
    settle_clear();
    check("underflow", flag_status[0], 1'b0);
    tx_data_required <= 1'b0;
    prev = last;
    xfer(8, 1'b0);
    check("echo", q, prev);
    repeat (8) @(posedge mclk);
    check("no_underflow", flag_status[0], 1'b0);
    $display("test underflow done");
    {rx_data_required, count_load} <= 2'b11;
    transfer_count_low <= 8'h05;
    @(posedge mclk);
    count_load <= 1'b0;
    xfer(4, 1'b0);
    repeat (8) @(posedge mclk);
    check("fault", flag_status[2], 1'b1);
    xfer(8, 1'b1);
    repeat (20) @(posedge mclk);
    check("rx_left", exp_q.size(), 16'h0000);
    {pin_direction_bit, select_force, rx_data_required} <= 3'b110;
    repeat (20) @(posedge mclk);
    check("sdo_oe", sdo_oe, 1'b0);
    $display("test fault done");
    tally_and_finish();
  end
endmodule : test_spism_engine
`default_nettype wire
